// File: pkg/dcu_defs.svh
// Offsets, field positions, reset values and timing counts for the bias DAC update control.
// Assumes a 32-bit Avalon-MM register bus with byte addresses and a 125 MHz core clock.
`ifndef DCU_DEFS_SVH
`define DCU_DEFS_SVH

`define DCU_NCH            8
`define DCU_CODE_W         13
`define DCU_LIM_W          6
`define DCU_ALARM_W        4

`define DCU_OFS_CHANNEL_POWER_ENABLE_REG     8'h00
`define DCU_OFS_SYNC_CFG   8'h04
`define DCU_OFS_TRIGGER    8'h08
`define DCU_OFS_BCAST      8'h0c
`define DCU_OFS_LIMIT      8'h10
`define DCU_OFS_OUT_CTRL   8'h14
`define DCU_OFS_FLEX_CFG   8'h18
`define DCU_OFS_AUTO_OFF   8'h1c
`define DCU_OFS_BUF_BASE   8'h20
`define DCU_OFS_ACT_BASE   8'h40
`define DCU_OFS_STATUS     8'h60
`define DCU_OFS_WIN_MASK   8'he0

`define DCU_SYNC_BC_POS    8
`define DCU_TRIG_SW_POS    0
`define DCU_OUT_PIN_POS    8
`define DCU_OUT_PA_POS     9
`define DCU_ST_SW_POS      8
`define DCU_ST_PA_POS      16
`define DCU_ST_ALM_POS     17
`define DCU_ST_RNG_POS     18

`define DCU_LIMIT_RST      6'h3f

`define DCU_CLK_NS         8
`define DCU_T_SW_NS        400
`define DCU_T_PA_NS        50
`define DCU_SW_CYC         (`DCU_T_SW_NS / `DCU_CLK_NS)
`define DCU_PA_CYC         (`DCU_T_PA_NS / `DCU_CLK_NS)

`endif

// File: pkg/dcu_pkg.sv
// Types shared by the bias DAC update control.
// Assumes the constants of dcu_defs.svh are used alongside.
package dcu_pkg;

	typedef enum logic [1:0] {
		DCU_BUS_IDLE = 2'b01,
		DCU_BUS_ACK  = 2'b10
	} dcu_bus_t;

	typedef enum logic [1:0] {
		DCU_FLEX_RESET = 2'h0,
		DCU_FLEX_LOAD  = 2'h1,
		DCU_FLEX_ALARM = 2'h2,
		DCU_FLEX_GPIO  = 2'h3
	} dcu_flex_t;

endpackage : dcu_pkg

// File: src/dcu_top.sv
// Code, power, switch and update control for eight bias DAC channels in two groups.
// Assumes an Avalon-MM master on core_clk and pins already synchronous to core_clk.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "dcu_defs.svh"

module dcu_top #(
	parameter int NCH     = `DCU_NCH,
	parameter int CODE_W  = `DCU_CODE_W,
	parameter int LIM_W   = `DCU_LIM_W,
	parameter int ALARM_W = `DCU_ALARM_W
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic [7:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic [1:0]                 switch_drive_enable_pin,
	input  wire logic                       multifunction_pin,
	input  wire logic [ALARM_W-1:0]         supply_alarm_status,
	input  wire logic [1:0]                 group_range_neg,
	output logic      [NCH-1:0][CODE_W-1:0] dac_code,
	output logic      [NCH-1:0]             buffer_power_on,
	output logic      [NCH-1:0]             clamp_on,
	output logic      [NCH-1:0]             switch_on,
	output logic                            amplifier_on_output
);

	localparam int SW_MAX = `DCU_SW_CYC;
	localparam int PA_MAX = `DCU_PA_CYC;
	localparam int LO_W   = CODE_W - LIM_W;

	typedef struct packed {
		dcu_pkg::dcu_bus_t          bus;
		logic [31:0]                rdata;
		logic [NCH-1:0]             channel_power_enable_reg;
		logic [NCH-1:0]             sync_en;
		logic [NCH-1:0]             bcast_en;
		logic [NCH-1:0]             sw_on;
		logic [NCH-1:0]             auto_off;
		logic                       pin_ctrl;
		logic                       pa_req;
		logic [1:0]                 flex_mode;
		logic [LIM_W-1:0]           limit;
		logic [CODE_W-1:0]          bcast;
		logic [NCH-1:0][CODE_W-1:0] buf_code;
		logic [NCH-1:0][CODE_W-1:0] pend;
		logic [NCH-1:0][CODE_W-1:0] act;
		logic                       flex_prev;
		logic [NCH-1:0]             pwr_q;
		logic [NCH-1:0]             sw_q;
		logic                       pa_q;
	} dcu_state_t;

	function automatic dcu_state_t rst_state();
		dcu_state_t r;
		r           = '0;
		r.bus       = dcu_pkg::DCU_BUS_IDLE;
		r.limit     = LIM_W'(`DCU_LIMIT_RST);
		r.flex_mode = dcu_pkg::DCU_FLEX_RESET;
		r.flex_prev = 1'b1;
		return r;
	endfunction : rst_state

	localparam dcu_state_t ST_RST = rst_state();

	// Upper bits above the limit are pulled down to it; low bits pass untouched
	function automatic logic [CODE_W-1:0] lim_code(
		input logic [CODE_W-1:0] c,
		input logic [LIM_W-1:0]  l
	);
		if (c[CODE_W-1 -: LIM_W] > l) begin
			return {l, c[LO_W-1:0]};
		end
		return c;
	endfunction : lim_code

	dcu_state_t        s_r;
	dcu_state_t        s_nxt;
	logic [31:0]       cur_rd;
	logic [31:0]       bmask;
	logic [31:0]       wval;
	logic [CODE_W-1:0] wcode;
	logic [CODE_W-1:0] wlim;
	logic              wr_go;
	logic              alarm_any;
	logic              load_trig;
	logic              sw_trig;
	logic              soft_rst;
	logic              in_buf;
	logic              in_act;
	logic [2:0]        ch_sel;

	assign wr_go     = avs_write && (s_r.bus == dcu_pkg::DCU_BUS_ACK);
	assign alarm_any = |supply_alarm_status;
	assign in_buf    = (avs_address & `DCU_OFS_WIN_MASK) == `DCU_OFS_BUF_BASE;
	assign in_act    = (avs_address & `DCU_OFS_WIN_MASK) == `DCU_OFS_ACT_BASE;
	assign ch_sel    = avs_address[4:2];
	// Active-low load strobe is taken on its falling edge so a held level fires once
	assign load_trig = (s_r.flex_mode == dcu_pkg::DCU_FLEX_LOAD)
		&& s_r.flex_prev && !multifunction_pin;
	assign soft_rst  = (s_r.flex_mode == dcu_pkg::DCU_FLEX_RESET) && !multifunction_pin;
	assign sw_trig   = wr_go && (avs_address == `DCU_OFS_TRIGGER)
		&& wval[`DCU_TRIG_SW_POS];
	assign wcode     = wval[CODE_W-1:0];
	assign wlim      = lim_code(wcode, s_r.limit);

	always_comb begin
		bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wval  = (cur_rd & ~bmask) | (avs_writedata & bmask);
	end

	// Read mux; also the old value for byte-lane merging on writes
	always_comb begin
		cur_rd = 32'h0000_0000;
		if (in_buf) begin
			cur_rd[CODE_W-1:0] = s_r.buf_code[ch_sel];
		end else if (in_act) begin
			cur_rd[CODE_W-1:0] = s_r.act[ch_sel];
		end else begin
			unique case (avs_address)
				`DCU_OFS_CHANNEL_POWER_ENABLE_REG: begin
					cur_rd[NCH-1:0] = s_r.channel_power_enable_reg;
				end
				`DCU_OFS_SYNC_CFG: begin
					cur_rd[NCH-1:0] = s_r.sync_en;
					cur_rd[`DCU_SYNC_BC_POS +: NCH] = s_r.bcast_en;
				end
				`DCU_OFS_BCAST: begin
					cur_rd[CODE_W-1:0] = s_r.bcast;
				end
				`DCU_OFS_LIMIT: begin
					cur_rd[LIM_W-1:0] = s_r.limit;
				end
				`DCU_OFS_OUT_CTRL: begin
					cur_rd[NCH-1:0] = s_r.sw_on;
					cur_rd[`DCU_OUT_PIN_POS] = s_r.pin_ctrl;
					cur_rd[`DCU_OUT_PA_POS] = s_r.pa_req;
				end
				`DCU_OFS_FLEX_CFG: begin
					cur_rd[1:0] = s_r.flex_mode;
				end
				`DCU_OFS_AUTO_OFF: begin
					cur_rd[NCH-1:0] = s_r.auto_off;
				end
				`DCU_OFS_STATUS: begin
					cur_rd[NCH-1:0] = s_r.pwr_q;
					cur_rd[`DCU_ST_SW_POS +: NCH] = s_r.sw_q;
					cur_rd[`DCU_ST_PA_POS] = s_r.pa_q;
					cur_rd[`DCU_ST_ALM_POS] = alarm_any;
					cur_rd[`DCU_ST_RNG_POS +: 2] = group_range_neg;
				end
				default: begin
					// Trigger reads as zero, unmapped words likewise
					cur_rd = 32'h0000_0000;
				end
			endcase
		end
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.flex_prev = multifunction_pin;
		unique case (s_r.bus)
			dcu_pkg::DCU_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					s_nxt.bus = dcu_pkg::DCU_BUS_ACK;
					s_nxt.rdata = avs_read ? cur_rd : 32'h0000_0000;
				end
			end
			dcu_pkg::DCU_BUS_ACK: begin
				s_nxt.bus = dcu_pkg::DCU_BUS_IDLE;
			end
			default: begin
				s_nxt.bus = dcu_pkg::DCU_BUS_IDLE;
			end
		endcase
		// Deferred channels take their pending code, on the load strobe channels 0 and 2 only; a write in this cycle wins after
		for (int k = 0; k < NCH; k++) begin
			if (s_r.sync_en[k] && (sw_trig || (load_trig && (k == 0 || k == 2)))) begin
				s_nxt.act[k] = s_r.pend[k];
			end
		end
		if (wr_go) begin
			if (in_buf) begin
				s_nxt.buf_code[ch_sel] = wcode;
				s_nxt.pend[ch_sel] = wlim;
				if (!s_r.sync_en[ch_sel]) begin
					s_nxt.act[ch_sel] = wlim;
				end
			end else begin
				unique case (avs_address)
					`DCU_OFS_CHANNEL_POWER_ENABLE_REG: begin
						s_nxt.channel_power_enable_reg = wval[NCH-1:0];
					end
					`DCU_OFS_SYNC_CFG: begin
						s_nxt.sync_en = wval[NCH-1:0];
						s_nxt.bcast_en = wval[`DCU_SYNC_BC_POS +: NCH];
					end
					`DCU_OFS_BCAST: begin
						s_nxt.bcast = wcode;
						for (int k = 0; k < NCH; k++) begin
							if (s_r.bcast_en[k]) begin
								s_nxt.buf_code[k] = wcode;
								s_nxt.pend[k] = wlim;
								s_nxt.act[k] = wlim;
							end
						end
					end
					`DCU_OFS_LIMIT: begin
						s_nxt.limit = wval[LIM_W-1:0];
					end
					`DCU_OFS_OUT_CTRL: begin
						s_nxt.sw_on = wval[NCH-1:0];
						s_nxt.pin_ctrl = wval[`DCU_OUT_PIN_POS];
						s_nxt.pa_req = wval[`DCU_OUT_PA_POS];
					end
					`DCU_OFS_FLEX_CFG: begin
						s_nxt.flex_mode = wval[1:0];
					end
					`DCU_OFS_AUTO_OFF: begin
						s_nxt.auto_off = wval[NCH-1:0];
					end
					default: begin
					end
				endcase
			end
		end
		// Buffers stay off, and outputs clamped, until enabled and, where auto-off is set, free of alarms
		s_nxt.pwr_q = s_r.channel_power_enable_reg & ~(s_r.auto_off & {NCH{alarm_any}});
		for (int k = 0; k < NCH; k++) begin
			// Group A follows the first drive pin, group B the second
			s_nxt.sw_q[k] = s_nxt.pwr_q[k] && (s_r.pin_ctrl
				? switch_drive_enable_pin[k >= NCH / 2] : s_r.sw_on[k]);
		end
		s_nxt.pa_q = s_r.pa_req
			&& !((s_r.flex_mode == dcu_pkg::DCU_FLEX_ALARM) && !multifunction_pin);
		// Reset event from the pin; the bus cycle in flight still completes
		if (soft_rst) begin
			s_nxt = ST_RST;
			s_nxt.bus = s_r.bus == dcu_pkg::DCU_BUS_IDLE && (avs_read || avs_write)
				? dcu_pkg::DCU_BUS_ACK : dcu_pkg::DCU_BUS_IDLE;
			s_nxt.rdata = avs_read ? cur_rd : 32'h0000_0000;
			s_nxt.flex_prev = multifunction_pin;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_waitrequest     = (avs_read || avs_write) && (s_r.bus != dcu_pkg::DCU_BUS_ACK);
	assign avs_readdata        = s_r.rdata;
	// Code drives the string DAC: out = code/8192 * span + range minimum
	assign dac_code            = s_r.act;
	assign buffer_power_on     = s_r.pwr_q;
	assign clamp_on            = ~s_r.pwr_q;
	assign switch_on           = s_r.sw_q;
	assign amplifier_on_output = s_r.pa_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	logic wr_buf0;
	logic full_be;
	assign full_be = avs_byteenable == 4'hf;
	assign wr_buf0 = wr_go && full_be && (avs_address == `DCU_OFS_BUF_BASE) && !soft_rst;

	chk_async_update: assert property (
		wr_buf0 && !s_r.sync_en[0] && (&s_r.limit)
		|=> dac_code[0] == $past(avs_writedata[CODE_W-1:0]))
		else $error("immediate write did not reach active code");

	chk_sync_hold: assert property (
		wr_buf0 && s_r.sync_en[0] && !sw_trig && !load_trig |=> $stable(dac_code[0]))
		else $error("deferred write changed active code");

	chk_load_pin_ch0: assert property (
		load_trig && s_r.sync_en[0] && !wr_go && !soft_rst
		|=> dac_code[0] == $past(s_r.pend[0]))
		else $error("load strobe did not update channel 0");

	chk_load_skip_ch1: assert property (
		load_trig && !wr_go && !soft_rst |=> $stable(dac_code[1]))
		else $error("load strobe touched channel 1");

	chk_trig_reads_zero: assert property (
		avs_read && s_r.bus == dcu_pkg::DCU_BUS_ACK && $past(avs_address) == `DCU_OFS_TRIGGER
		|-> avs_readdata[`DCU_TRIG_SW_POS] == 1'b0)
		else $error("trigger bit read back as one");

	chk_alarm_pa_off: assert property (
		s_r.flex_mode == dcu_pkg::DCU_FLEX_ALARM && !multifunction_pin
		|-> ##[1:PA_MAX] !amplifier_on_output)
		else $error("amplifier-on not dropped after alarm");

	chk_pin_switch_off: assert property (
		s_r.pin_ctrl && !switch_drive_enable_pin[0] && !soft_rst
		|-> ##[1:SW_MAX] !switch_on[0])
		else $error("switch did not follow drive pin");

	chk_bcast_load: assert property (
		wr_go && full_be && avs_address == `DCU_OFS_BCAST && s_r.bcast_en[1]
		&& (&s_r.limit) && !soft_rst
		|=> dac_code[1] == $past(avs_writedata[CODE_W-1:0]))
		else $error("broadcast value not in active code");

	chk_limit_upper: assert property (
		wr_buf0 && !s_r.sync_en[0]
		|=> dac_code[0][CODE_W-1 -: LIM_W] <= $past(s_r.limit))
		else $error("code limit not applied");

	chk_power_cause: assert property (
		$rose(buffer_power_on[0]) |-> $past(s_r.channel_power_enable_reg[0]) && !clamp_on[0])
		else $error("buffer powered without enable bit");

	chk_reset_clear: assert property (
		soft_rst |=> dac_code == '0 && buffer_power_on == '0 && clamp_on == '1)
		else $error("reset event left state behind");

	chk_auto_off: assert property (
		alarm_any && s_r.auto_off[0] |=> !buffer_power_on[0])
		else $error("alarm did not power down channel");

	chk_soft_switch: assert property (
		!s_r.pin_ctrl && !s_r.sw_on[0] |=> !switch_on[0])
		else $error("switch on without software enable");

	chk_clamp_unpowered: assert property (
		!s_r.channel_power_enable_reg[0] |=> clamp_on[0] && !buffer_power_on[0])
		else $error("output unclamped without power enable");

	cov_sw_trigger: cover property (sw_trig && s_r.sync_en[0]);
	cov_load_trigger: cover property (load_trig && s_r.sync_en[2]);
	cov_bcast_write: cover property (wr_go && avs_address == `DCU_OFS_BCAST && |s_r.bcast_en);
	cov_alarm_off: cover property ($fell(amplifier_on_output));
	cov_limit_hit: cover property (wr_buf0 && wlim != wcode);

endmodule : dcu_top

// File: verification/dcu_host_model.sv
// Host controller model: Avalon-MM master for the register port of dcu_top.
// Assumes a single-clock slave that answers through waitrequest on core_clk.
`timescale 1ns/1ns
module dcu_host_model (
	input  wire logic        core_clk,
	output logic      [7:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end

	// Request stands until waitrequest is sampled low; bounded so a hang is reported
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		q = 32'h0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		while (!ok && n < 100) begin
			@(posedge core_clk);
			n++;
			if (avs_waitrequest === 1'b0) begin
				ok = 1'b1;
				q = avs_readdata;
				avs_write <= 1'b0;
				avs_read <= 1'b0;
			end
		end
	endtask : xfer
endmodule : dcu_host_model

// File: verification/dcu_top_bench.sv
// Self-checking bench for dcu_top: codes, update modes, broadcast, limit, switches, alarms.
// Assumes the host model drives the register port; pins driven here on core_clk.
`timescale 1ns/1ns
`include "dcu_defs.svh"
module dcu_top_bench;
	logic             core_clk;
	logic             rst;
	logic [7:0]       avs_address;
	logic             avs_read;
	logic             avs_write;
	logic [31:0]      avs_writedata;
	logic [3:0]       avs_byteenable;
	logic [31:0]      avs_readdata;
	logic             avs_waitrequest;
	logic [1:0]       switch_drive_enable_pin;
	logic             multifunction_pin;
	logic [3:0]       supply_alarm_status;
	logic [1:0]       group_range_neg;
	logic [7:0][12:0] dac_code;
	logic [7:0]       buffer_power_on;
	logic [7:0]       clamp_on;
	logic [7:0]       switch_on;
	logic             amplifier_on_output;
	int               error_cnt;
	int               compares;

	dcu_top dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .switch_drive_enable_pin(switch_drive_enable_pin),
		.multifunction_pin(multifunction_pin), .supply_alarm_status(supply_alarm_status),
		.group_range_neg(group_range_neg), .dac_code(dac_code),
		.buffer_power_on(buffer_power_on), .clamp_on(clamp_on), .switch_on(switch_on),
		.amplifier_on_output(amplifier_on_output));

	dcu_host_model host (.core_clk(core_clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic ok;
		host.xfer(1'b0, a, 32'h0, q, ok);
		if (!ok) begin
			error_cnt++;
			final_report();
		end
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        ok;
		host.xfer(1'b1, a, d, q, ok);
		if (!ok) begin
			error_cnt++;
			final_report();
		end
	endtask : wr

	// Only 13-bit codes are ever handed to the bus
	task automatic wbuf(input int ch, input logic [12:0] c);
		wr(`DCU_OFS_BUF_BASE + 8'(ch * 4), {19'h0, c});
	endtask : wbuf

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic code_is(input int ch, input logic [12:0] c);
		chk({19'h0, dac_code[ch]}, {19'h0, c});
	endtask : code_is

	task automatic t_cleared;
		for (int ch = 0; ch < 8; ch++) code_is(ch, 13'h0000);
		chk({24'h0, buffer_power_on}, 32'h0);
		chk({24'h0, clamp_on}, 32'h000000ff);
		chk({24'h0, switch_on}, 32'h0);
	endtask : t_cleared

	task automatic t_reset;
		logic [31:0] q;
		t_cleared();
		rd(`DCU_OFS_LIMIT, q);
		chk(q, 32'h0000003f);
		$display("test reset done");
	endtask : t_reset

	task automatic t_power;
		wr(`DCU_OFS_CHANNEL_POWER_ENABLE_REG, 32'h000000a5);
		cyc(3);
		chk({24'h0, buffer_power_on}, 32'h000000a5);
		chk({24'h0, clamp_on}, 32'h0000005a);
		$display("test power done");
	endtask : t_power

	task automatic t_async;
		logic [31:0] q;
		wr(`DCU_OFS_SYNC_CFG, 32'h0);
		wbuf(3, 13'h1fff);
		cyc(2);
		code_is(3, 13'h1fff);
		rd(`DCU_OFS_ACT_BASE + 8'h0c, q);
		chk(q, 32'h00001fff);
		wbuf(3, 13'h1000);
		cyc(2);
		code_is(3, 13'h1000);
		$display("test immediate update done");
	endtask : t_async

	task automatic t_sync;
		logic [31:0] q;
		wr(`DCU_OFS_SYNC_CFG, 32'h000000ff);
		wbuf(1, 13'h1000);
		wbuf(5, 13'h0123);
		cyc(2);
		code_is(1, 13'h0000);
		code_is(5, 13'h0000);
		wr(`DCU_OFS_TRIGGER, 32'h1);
		cyc(2);
		code_is(1, 13'h1000);
		code_is(5, 13'h0123);
		rd(`DCU_OFS_TRIGGER, q);
		chk(q, 32'h0);
		wbuf(1, 13'h0001);
		cyc(4);
		code_is(1, 13'h1000);
		$display("test deferred update done");
	endtask : t_sync

	task automatic t_load;
		wr(`DCU_OFS_FLEX_CFG, 32'h1);
		wbuf(0, 13'h0aaa);
		wbuf(2, 13'h0ccc);
		wbuf(4, 13'h0444);
		multifunction_pin <= 1'b0;
		cyc(1);
		multifunction_pin <= 1'b1;
		cyc(3);
		code_is(0, 13'h0aaa);
		code_is(2, 13'h0ccc);
		code_is(1, 13'h1000);
		code_is(4, 13'h0000);
		wr(`DCU_OFS_FLEX_CFG, 32'h0);
		$display("test load strobe done");
	endtask : t_load

	task automatic t_bcast;
		logic [31:0] q;
		wr(`DCU_OFS_SYNC_CFG, 32'h00005200);
		wr(`DCU_OFS_BCAST, 32'h00000abc);
		cyc(2);
		code_is(1, 13'h0abc);
		code_is(4, 13'h0abc);
		code_is(6, 13'h0abc);
		code_is(5, 13'h0123);
		rd(`DCU_OFS_BUF_BASE + 8'h10, q);
		chk(q, 32'h00000abc);
		$display("test broadcast done");
	endtask : t_bcast

	task automatic t_limit;
		logic [31:0] q;
		wbuf(0, 13'h1fff);
		wr(`DCU_OFS_LIMIT, 32'h10);
		cyc(2);
		code_is(0, 13'h1fff);
		wbuf(0, 13'h1fff);
		cyc(2);
		code_is(0, 13'h087f);
		rd(`DCU_OFS_BUF_BASE, q);
		chk(q, 32'h00001fff);
		wbuf(0, 13'h0855);
		cyc(2);
		code_is(0, 13'h0855);
		wr(`DCU_OFS_LIMIT, 32'h3f);
		$display("test code limit done");
	endtask : t_limit

	task automatic t_switch;
		logic [31:0] q;
		wr(`DCU_OFS_CHANNEL_POWER_ENABLE_REG, 32'h000000ff);
		wr(`DCU_OFS_OUT_CTRL, 32'h00000300);
		switch_drive_enable_pin <= 2'b01;
		cyc(3);
		chk({24'h0, switch_on}, 32'h0000000f);
		switch_drive_enable_pin <= 2'b10;
		cyc(3);
		chk({24'h0, switch_on}, 32'h000000f0);
		wr(`DCU_OFS_OUT_CTRL, 32'h000002c3);
		cyc(3);
		chk({24'h0, switch_on}, 32'h000000c3);
		rd(`DCU_OFS_STATUS, q);
		chk(q, 32'h0009c3ff);
		$display("test switches done");
	endtask : t_switch

	task automatic t_alarm;
		chk({31'h0, amplifier_on_output}, 32'h1);
		wr(`DCU_OFS_FLEX_CFG, 32'h2);
		multifunction_pin <= 1'b0;
		cyc(2);
		chk({31'h0, amplifier_on_output}, 32'h0);
		multifunction_pin <= 1'b1;
		cyc(2);
		wr(`DCU_OFS_FLEX_CFG, 32'h0);
		wr(`DCU_OFS_AUTO_OFF, 32'h00000003);
		supply_alarm_status <= 4'h4;
		cyc(3);
		chk({24'h0, buffer_power_on}, 32'h000000fc);
		chk({24'h0, switch_on}, 32'h000000c0);
		supply_alarm_status <= 4'h0;
		cyc(3);
		chk({24'h0, buffer_power_on}, 32'h000000ff);
		multifunction_pin <= 1'b0;
		cyc(2);
		multifunction_pin <= 1'b1;
		cyc(2);
		t_cleared();
		$display("test alarms and pin reset done");
	endtask : t_alarm

	initial begin
		rst = 1'b1;
		switch_drive_enable_pin = 2'b00;
		multifunction_pin = 1'b1;
		supply_alarm_status = 4'h0;
		group_range_neg = 2'b10;
		error_cnt = 0;
		compares = 0;
		cyc(10);
		rst <= 1'b0;
		t_reset();
		t_power();
		t_async();
		t_sync();
		t_load();
		t_bcast();
		t_limit();
		t_switch();
		t_alarm();
		final_report();
	end
endmodule : dcu_top_bench
